// File: dv/lbi_bus_monitor.sv
// Checker for the local bus between the two ends.
// Assumes the signals of one lbi_bus_if instance with its clock and reset.
`timescale 1ns/10ps
`include "lbi_cfg.svh"

module lbi_bus_monitor (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic devDataOe,
   input wire logic devBusOe,
   input wire logic devAdsN,
   input wire logic [`LBI_WADDR_W-1:0] devWordAddr,
   input wire logic [`LBI_LANES-1:0] byteLaneEnableN,
   input wire logic [`LBI_WADDR_W-1:0] wordAddressOut,
   input wire logic addressStrobeN,
   input wire logic memIoSel,
   input wire logic holdGrantedOut
);
   logic phaseReg;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // ==========================================
   // Mirror of the internal clock phase
   // ==========================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phaseReg <= 1'h0;
      end else begin
         phaseReg <= ~phaseReg;
      end
   end

   // ==========================================
   // Properties
   // ==========================================
   sequence s_strobe_end;
      !devAdsN ##1 devAdsN;
   endsequence
   sequence s_idle_before;
      $past(devAdsN) && $past(devAdsN, 2);
   endsequence

   property p_release;
      holdGrantedOut |-> !devBusOe && !devDataOe;
   endproperty
   property p_grant_idle;
      $rose(holdGrantedOut) |-> s_idle_before;
   endproperty
   property p_strobe_len;
      $fell(devAdsN) |=> s_strobe_end;
   endproperty
   property p_phase;
      $fell(devAdsN) |-> !phaseReg;
   endproperty
   property p_lanes;
      !addressStrobeN |-> (~byteLaneEnableN) inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6,
         4'hc, 4'h7, 4'he, 4'hf};
   endproperty
   property p_io_range;
      !addressStrobeN && !memIoSel && !wordAddressOut[29] |-> wordAddressOut[29:14] == 16'h0;
   endproperty
   property p_copro;
      !addressStrobeN && !memIoSel && wordAddressOut[29] |-> wordAddressOut[29:1] == 29'h1000001f;
   endproperty
   property p_addr_hold;
      $changed(devWordAddr) && devBusOe && $past(devBusOe) |-> $fell(devAdsN);
   endproperty

   a_release: assert property (p_release) else $error("bus driven under grant");
   a_grant_idle: assert property (p_grant_idle) else $error("grant mid cycle");
   a_strobe_len: assert property (p_strobe_len) else $error("strobe length");
   a_phase: assert property (p_phase) else $error("strobe off phase");
   a_lanes: assert property (p_lanes) else $error("lane pattern");
   a_io_range: assert property (p_io_range) else $error("io address range");
   a_copro: assert property (p_copro) else $error("coprocessor address");
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
endmodule

// File: dv/tb_top.sv
// Bench joining both ends of the local bus; drives the core and system sides.
// Assumes the package, interface and both ends are compiled before it.
`timescale 1ns/10ps
`include "lbi_cfg.svh"

module tb_top;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic reqValid = 1'h0;
   logic reqWrite = 1'h0;
   logic reqMio = 1'h1;
   logic reqCopro = 1'h0;
   logic [29:0] reqWordAddr = 30'h0;
   logic [3:0] reqByteEn = 4'hf;
   logic [31:0] reqData = 32'h0;
   logic [3:0] waitStates = 4'h0;
   logic pipeEnable = 1'h0;
   logic halfWidthSel = 1'h0;
   logic holdRequestIn = 1'h0;
   logic [31:0] rdData = 32'h0;
   logic reqAck, rspValid, holdGranted, cycValid, cycMio, cycDc, cycWr;
   logic [31:0] rspData, cycData, m, d;
   logic [29:0] cycWordAddr;
   logic [3:0] cycBeN;
   logic [68:0] cycQ[$];
   logic [3:0] beTab[10] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf};
   int failures = 0;
   int cmpCount = 0;
   int k;
   time t0;

   lbi_bus_if i_lbi_bus_if ();
   lbi_dev_end i_lbi_dev_end (.ref_clk, .rst_n, .bus(i_lbi_bus_if), .reqValid, .reqWrite,
      .reqMio, .reqDc(1'h1), .reqCopro, .reqWordAddr, .reqByteEn, .reqData, .reqAck,
      .rspValid, .rspData);
   lbi_host_end i_lbi_host_end (.ref_clk, .rst_n, .bus(i_lbi_bus_if), .waitStates,
      .pipeEnable, .halfWidthSel, .holdRequestIn, .rdData, .holdGranted, .cycValid,
      .cycWordAddr, .cycBeN, .cycMio, .cycDc, .cycWr, .cycData);
   lbi_bus_monitor i_lbi_bus_monitor (.ref_clk, .rst_n, .devDataOe(i_lbi_bus_if.devDataOe),
      .devBusOe(i_lbi_bus_if.devBusOe), .devAdsN(i_lbi_bus_if.devAdsN),
      .devWordAddr(i_lbi_bus_if.devWordAddr), .byteLaneEnableN(i_lbi_bus_if.byteLaneEnableN),
      .wordAddressOut(i_lbi_bus_if.wordAddressOut),
      .addressStrobeN(i_lbi_bus_if.addressStrobeN), .memIoSel(i_lbi_bus_if.memIoSel),
      .holdGrantedOut(i_lbi_bus_if.holdGrantedOut));

   always #4 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (cycValid === 1'h1) begin
         cycQ.push_back({cycWordAddr, cycBeN, cycMio, cycDc, cycWr, cycData});
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task chk_val(input logic [68:0] got, input logic [68:0] exp);
      cmpCount++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits on reqAck, rspValid, holdGranted or a logged cycle, bounded.
   task wait_sig(input int which, output int n);
      n = 0;
      while (n < 300 && (which == 0 ? reqAck : which == 1 ? rspValid :
             which == 2 ? holdGranted : cycQ.size() > 0) !== 1'h1) begin
         tick(1);
         n++;
      end
      if (n == 300) begin
         failures++;
         print_verdict();
      end
   endtask

   task chk_cyc(input logic [29:0] a, input logic [3:0] b, input logic mi, input logic w,
                input logic [31:0] dat, input logic [31:0] msk);
      logic [68:0] g;
      int j;
      wait_sig(3, j);
      g = cycQ.pop_front();
      g[31:0] = g[31:0] & msk;
      chk_val(g, {a, b, mi, 1'h1, w, dat & msk});
   endtask

   task req(input logic w, input logic mi, input logic c, input logic [29:0] a,
            input logic [3:0] be, input logic [31:0] dat);
      {reqWrite, reqMio, reqCopro, reqWordAddr, reqByteEn, reqData} = {w, mi, c, a, be, dat};
      reqValid = 1'h1;
      wait_sig(0, k);
      reqValid = 1'h0;
      tick(1);
   endtask

   initial begin
      tick(2);
      rst_n = 1'h1;
      req(1'h1, 1'h1, 1'h0, 30'h0abcdef, 4'hf, 32'h89abcdef);
      chk_cyc(30'h0abcdef, 4'h0, 1'h1, 1'h1, 32'h89abcdef, '1);
      for (int w = 0; w < 3; w++) begin
         waitStates = w[3:0];
         rdData = 32'h5a3c0000 + w;
         req(1'h0, 1'h1, 1'h0, 30'h100, 4'hf, 32'h0);
         wait_sig(1, k);
         chk_val(k, 3 + 2 * w);
         chk_val(rspData, rdData);
         chk_cyc(30'h100, 4'h0, 1'h1, 1'h0, rdData, '1);
      end
      waitStates = 4'h0;
      for (int i = 0; i < 10; i++) begin
         m = {{8{beTab[i][3]}}, {8{beTab[i][2]}}, {8{beTab[i][1]}}, {8{beTab[i][0]}}};
         d = 32'hc3a59612 + i;
         req(1'h1, 1'h1, 1'h0, 30'h200, beTab[i], d);
         if (beTab[i][1:0] == 2'h0) begin
            chk_cyc(30'h200, ~beTab[i], 1'h1, 1'h1, {d[31:16], d[31:16]}, m | m >> 16);
         end else begin
            chk_cyc(30'h200, ~beTab[i], 1'h1, 1'h1, d, m);
         end
      end
      halfWidthSel = 1'h1;
      d = 32'h13579bdf;
      req(1'h1, 1'h1, 1'h0, 30'h300, 4'hf, d);
      chk_cyc(30'h300, 4'h0, 1'h1, 1'h1, d, '1);
      chk_cyc(30'h300, 4'h3, 1'h1, 1'h1, {d[31:16], d[31:16]}, '1);
      rdData = 32'h2468ace0;
      req(1'h0, 1'h1, 1'h0, 30'h301, 4'hf, 32'h0);
      wait_sig(1, k);
      chk_val(rspData, rdData);
      chk_cyc(30'h301, 4'h0, 1'h1, 1'h0, rdData, 32'h0000ffff);
      chk_cyc(30'h301, 4'h3, 1'h1, 1'h0, {rdData[31:16], rdData[31:16]}, 32'h0000ffff);
      halfWidthSel = 1'h0;
      req(1'h1, 1'h0, 1'h0, 30'h12345, 4'hf, d);
      chk_cyc(30'h2345, 4'h0, 1'h0, 1'h1, d, '1);
      req(1'h1, 1'h0, 1'h1, 30'h3, 4'hf, d);
      chk_cyc(30'h2000003f, 4'h0, 1'h0, 1'h1, d, '1);
      pipeEnable = 1'h1;
      waitStates = 4'h3;
      req(1'h1, 1'h1, 1'h0, 30'h40, 4'h3, d);
      t0 = $time;
      req(1'h1, 1'h1, 1'h0, 30'h41, 4'hf, ~d);
      chk_val($time - t0 < 48, 1);
      chk_cyc(30'h40, 4'hc, 1'h1, 1'h1, d, '1);
      chk_cyc(30'h41, 4'h0, 1'h1, 1'h1, ~d, '1);
      pipeEnable = 1'h0;
      waitStates = 4'h0;
      holdRequestIn = 1'h1;
      wait_sig(2, k);
      t0 = $time;
      fork
         req(1'h1, 1'h1, 1'h0, 30'h50, 4'hf, d);
         begin
            tick(10);
            holdRequestIn = 1'h0;
         end
      join
      chk_val($time - t0 > 80, 1);
      chk_cyc(30'h50, 4'h0, 1'h1, 1'h1, d, '1);
      print_verdict();
   end
endmodule

// File: verilog/lbi_bus_if.sv
// Local bus between the processor end and the system end.
// Assumes both ends run on the same double-rate clock; the shared data
// wire and the released address pins are resolved here from the enables.
`timescale 1ns/10ps
`include "lbi_cfg.svh"

interface lbi_bus_if;
   logic [`LBI_DATA_W-1:0] devData;
   logic devDataOe;
   logic [`LBI_DATA_W-1:0] hostData;
   logic hostDataOe;
   logic [`LBI_DATA_W-1:0] bidirDataLines;
   logic devBusOe;
   logic [`LBI_LANES-1:0] devBeN;
   logic [`LBI_WADDR_W-1:0] devWordAddr;
   logic devAdsN;
   logic devMio;
   logic devDc;
   logic devWr;
   logic [`LBI_LANES-1:0] byteLaneEnableN;
   logic [`LBI_WADDR_W-1:0] wordAddressOut;
   logic addressStrobeN;
   logic memIoSel;
   logic dataCodeSel;
   logic writeReadSel;
   logic cycleAckN;
   logic nextAddressRequestN;
   logic halfWidthRequestN;
   logic holdRequest;
   logic holdGrantedOut;

   // A floating wire reads as pulled: data low, strobes and enables high.
   assign bidirDataLines = devDataOe ? devData : (hostDataOe ? hostData : '0);
   assign byteLaneEnableN = devBusOe ? devBeN : '1;
   assign wordAddressOut = devBusOe ? devWordAddr : '0;
   assign addressStrobeN = devBusOe ? devAdsN : 1'b1;
   assign memIoSel = devBusOe ? devMio : 1'b1;
   assign dataCodeSel = devBusOe ? devDc : 1'b1;
   assign writeReadSel = devBusOe ? devWr : 1'b1;

   modport dev (
      output devData, devDataOe, devBusOe, devBeN, devWordAddr, devAdsN,
      output devMio, devDc, devWr, holdGrantedOut,
      input bidirDataLines, cycleAckN, nextAddressRequestN, halfWidthRequestN,
      input holdRequest
   );

   modport host (
      output hostData, hostDataOe, cycleAckN, nextAddressRequestN,
      output halfWidthRequestN, holdRequest,
      input bidirDataLines, byteLaneEnableN, wordAddressOut, addressStrobeN,
      input memIoSel, dataCodeSel, writeReadSel, holdGrantedOut
   );
endinterface

// File: verilog/lbi_cfg.svh
// Constants shared by both ends of the local bus and by the package.
// Assumes it is included by bare name before any use of its macros.
`ifndef LBI_CFG_SVH
`define LBI_CFG_SVH

`define LBI_DATA_W 32
`define LBI_WADDR_W 30
`define LBI_LANES 4
`define LBI_WAIT_W 4
`define LBI_HALF_W 16

// Coprocessor I/O words 800000F8H and 800000FCH, as word addresses.
`define LBI_COPRO_WORD_BASE 30'h2000003e
// Programmed I/O words stay inside 0000H..FFFFH.
`define LBI_IO_WORD_MASK 30'h00003fff

`define LBI_LOW_LANES 4'h3
`define LBI_HIGH_LANES 4'hc
`define LBI_NO_LANES_N 2'h3
`define LBI_PHASE_RESET 1'b0
`define LBI_TICK_PHASE 1'b1
`define LBI_WAIT_ZERO 4'h0
`define LBI_WAIT_ONE 4'h1

`endif

// File: verilog/lbi_dev_end.sv
// Processor end of the local bus: runs bus cycles for requests from the
// core side, with byte lanes, half-width splitting, pipelined addresses
// and bus release under hold.
// Assumes the system end shares ref_clk and rst_n and ends every cycle.
`timescale 1ns/10ps
`include "lbi_cfg.svh"

module lbi_dev_end (
   input wire logic ref_clk,
   input wire logic rst_n,
   lbi_bus_if.dev bus,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqMio,
   input wire logic reqDc,
   input wire logic reqCopro,
   input wire logic [`LBI_WADDR_W-1:0] reqWordAddr,
   input wire logic [`LBI_LANES-1:0] reqByteEn,
   input wire logic [`LBI_DATA_W-1:0] reqData,
   output logic reqAck,
   output logic rspValid,
   output logic [`LBI_DATA_W-1:0] rspData
);
   logic phaseReg;
   logic tick;
   lbi_pkg::lbi_dev_state_t stateReg;
   lbi_pkg::lbi_cyc_t reqCyc;
   lbi_pkg::lbi_cyc_t curReg;
   lbi_pkg::lbi_cyc_t nxtReg;
   logic nxtValidReg;
   logic [`LBI_DATA_W-1:0] rdAccReg;
   logic [`LBI_DATA_W-1:0] rdMerged;
   logic halfSeen;
   logic spans;
   logic ackSeen;
   logic split;
   logic finish;
   logic canPipe;
   logic canStart;

   // Copies the upper half onto the lower lanes when only upper lanes move.
   function automatic logic [`LBI_DATA_W-1:0] dupData(
      input logic [`LBI_LANES-1:0] be,
      input logic [`LBI_DATA_W-1:0] d
   );
      logic [`LBI_DATA_W-1:0] r;
      r = d;
      if ((be & `LBI_LOW_LANES) == '0) begin
         r[`LBI_HALF_W-1:0] = d[`LBI_DATA_W-1:`LBI_HALF_W];
      end
      return r;
   endfunction

   // Folds the lanes of one acknowledged read into the gathered word.
   function automatic logic [`LBI_DATA_W-1:0] mergeRead(
      input logic [`LBI_DATA_W-1:0] acc,
      input logic [`LBI_LANES-1:0] be,
      input logic half,
      input logic [`LBI_DATA_W-1:0] lines
   );
      logic [`LBI_DATA_W-1:0] r;
      r = acc;
      if (half && ((be & `LBI_LOW_LANES) == '0)) begin
         r[`LBI_DATA_W-1:`LBI_HALF_W] = lines[`LBI_HALF_W-1:0];
      end else begin
         for (int i = 0; i < `LBI_LANES; i++) begin
            if (be[i] && !(half && i >= `LBI_LANES/2)) begin
               r[8*i +: 8] = lines[8*i +: 8];
            end
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Internal clock: every second edge of ref_clk is a bus state edge
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phaseReg <= `LBI_PHASE_RESET;
      end else begin
         phaseReg <= ~phaseReg;
      end
   end
   assign tick = (phaseReg == `LBI_TICK_PHASE);

   // ==========================================================
   // Request shaping: address space, coprocessor, duplication
   // ==========================================================
   always_comb begin
      reqCyc.wordAddr = reqWordAddr;
      reqCyc.be = reqByteEn;
      reqCyc.mio = reqMio;
      reqCyc.dc = reqDc;
      reqCyc.wr = reqWrite;
      reqCyc.data = dupData(reqByteEn, reqData);
      if (reqCopro) begin
         reqCyc.mio = 1'b0;
         reqCyc.dc = 1'b1;
         reqCyc.wordAddr = `LBI_COPRO_WORD_BASE | {{(`LBI_WADDR_W-1){1'b0}}, reqWordAddr[0]};
      end else if (!reqMio) begin
         reqCyc.wordAddr = reqWordAddr & `LBI_IO_WORD_MASK;
      end
   end

   assign halfSeen = !bus.halfWidthRequestN;
   assign spans = ((curReg.be & `LBI_LOW_LANES) != '0) && ((curReg.be & `LBI_HIGH_LANES) != '0);
   assign ackSeen = tick && (stateReg == lbi_pkg::LBI_T2) && !bus.cycleAckN;
   assign split = ackSeen && halfSeen && spans;
   assign finish = ackSeen && !split;
   assign canStart = reqValid && !bus.holdRequest;
   assign canPipe = tick && (stateReg == lbi_pkg::LBI_T2) && bus.cycleAckN && !nxtValidReg &&
      !bus.nextAddressRequestN && canStart && !spans;
   assign rdMerged = mergeRead(rdAccReg, curReg.be, halfSeen, bus.bidirDataLines);

   // ==========================================================
   // Read capture and answer
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdAccReg <= '0;
         rspValid <= 1'b0;
         rspData <= '0;
      end else begin
         rspValid <= 1'b0;
         if (ackSeen && !curReg.wr) begin
            if (split) begin
               rdAccReg <= rdMerged;
            end else begin
               rdAccReg <= '0;
               rspValid <= 1'b1;
               rspData <= rdMerged;
            end
         end
      end
   end

   // ==========================================================
   // Bus state machine and pins
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         stateReg <= lbi_pkg::LBI_IDLE;
         curReg <= '0;
         nxtReg <= '0;
         nxtValidReg <= 1'b0;
         reqAck <= 1'b0;
         bus.devBusOe <= 1'b1;
         bus.devDataOe <= 1'b0;
         bus.devData <= '0;
         bus.devBeN <= '1;
         bus.devWordAddr <= '0;
         bus.devAdsN <= 1'b1;
         bus.devMio <= 1'b0;
         bus.devDc <= 1'b0;
         bus.devWr <= 1'b0;
         bus.holdGrantedOut <= 1'b0;
      end else begin
         reqAck <= 1'b0;
         if (tick) begin
            unique case (stateReg)
               lbi_pkg::LBI_IDLE: begin
                  if (bus.holdRequest) begin
                     stateReg <= lbi_pkg::LBI_HOLD;
                     bus.holdGrantedOut <= 1'b1;
                     bus.devBusOe <= 1'b0;
                  end else if (canStart) begin
                     stateReg <= lbi_pkg::LBI_T1;
                     curReg <= reqCyc;
                     bus.devData <= reqCyc.data;
                     bus.devDataOe <= reqCyc.wr;
                     bus.devBeN <= ~reqCyc.be;
                     bus.devWordAddr <= reqCyc.wordAddr;
                     {bus.devMio, bus.devDc, bus.devWr} <= {reqCyc.mio, reqCyc.dc, reqCyc.wr};
                     bus.devAdsN <= 1'b0;
                     reqAck <= 1'b1;
                  end
               end
               lbi_pkg::LBI_HOLD: begin
                  if (!bus.holdRequest) begin
                     stateReg <= lbi_pkg::LBI_IDLE;
                     bus.holdGrantedOut <= 1'b0;
                     bus.devBusOe <= 1'b1;
                  end
               end
               lbi_pkg::LBI_T1, lbi_pkg::LBI_P1: begin
                  stateReg <= lbi_pkg::LBI_T2;
                  bus.devAdsN <= 1'b1;
               end
               lbi_pkg::LBI_T2: begin
                  if (split) begin
                     stateReg <= lbi_pkg::LBI_T1;
                     curReg.be <= curReg.be & `LBI_HIGH_LANES;
                     bus.devData <= dupData(`LBI_HIGH_LANES, curReg.data);
                     bus.devBeN <= ~(curReg.be & `LBI_HIGH_LANES);
                     bus.devAdsN <= 1'b0;
                  end else if (finish && nxtValidReg) begin
                     stateReg <= lbi_pkg::LBI_P1;
                     curReg <= nxtReg;
                     nxtValidReg <= 1'b0;
                     bus.devData <= nxtReg.data;
                     bus.devDataOe <= nxtReg.wr;
                     bus.devAdsN <= 1'b1;
                  end else if (finish && canStart) begin
                     stateReg <= lbi_pkg::LBI_T1;
                     curReg <= reqCyc;
                     bus.devData <= reqCyc.data;
                     bus.devDataOe <= reqCyc.wr;
                     bus.devBeN <= ~reqCyc.be;
                     bus.devWordAddr <= reqCyc.wordAddr;
                     {bus.devMio, bus.devDc, bus.devWr} <= {reqCyc.mio, reqCyc.dc, reqCyc.wr};
                     bus.devAdsN <= 1'b0;
                     reqAck <= 1'b1;
                  end else if (finish) begin
                     stateReg <= lbi_pkg::LBI_IDLE;
                     bus.devDataOe <= 1'b0;
                     bus.devAdsN <= 1'b1;
                  end else if (canPipe) begin
                     nxtReg <= reqCyc;
                     nxtValidReg <= 1'b1;
                     bus.devBeN <= ~reqCyc.be;
                     bus.devWordAddr <= reqCyc.wordAddr;
                     {bus.devMio, bus.devDc, bus.devWr} <= {reqCyc.mio, reqCyc.dc, reqCyc.wr};
                     bus.devAdsN <= 1'b0;
                     reqAck <= 1'b1;
                  end else begin
                     bus.devAdsN <= 1'b1;
                  end
               end
               default: begin
                  stateReg <= lbi_pkg::LBI_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// File: verilog/lbi_host_end.sv
// System end of the local bus: decodes cycles, inserts wait states,
// answers with the acknowledge, and steers pipelining, width and hold.
// Assumes the device end shares ref_clk and rst_n.
`timescale 1ns/10ps
`include "lbi_cfg.svh"

module lbi_host_end (
   input wire logic ref_clk,
   input wire logic rst_n,
   lbi_bus_if.host bus,
   input wire logic [`LBI_WAIT_W-1:0] waitStates,
   input wire logic pipeEnable,
   input wire logic halfWidthSel,
   input wire logic holdRequestIn,
   input wire logic [`LBI_DATA_W-1:0] rdData,
   output logic holdGranted,
   output logic cycValid,
   output logic [`LBI_WADDR_W-1:0] cycWordAddr,
   output logic [`LBI_LANES-1:0] cycBeN,
   output logic cycMio,
   output logic cycDc,
   output logic cycWr,
   output logic [`LBI_DATA_W-1:0] cycData
);
   logic phaseReg;
   logic tick;
   logic busyReg;
   logic pendReg;
   logic ackNReg;
   logic [`LBI_WAIT_W-1:0] waitCntReg;
   logic [`LBI_WADDR_W-1:0] curAddrReg;
   logic [`LBI_LANES-1:0] curBeNReg;
   logic [2:0] curDefReg;
   logic [`LBI_WADDR_W-1:0] pendAddrReg;
   logic [`LBI_LANES-1:0] pendBeNReg;
   logic [2:0] pendDefReg;
   logic adsSeen;
   logic half;
   logic upperOnly;
   logic [`LBI_DATA_W-1:0] rdDrive;
   logic [`LBI_DATA_W-1:0] wrTaken;

   // ==========================================================
   // Phase, aligned by the same reset as the device end
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phaseReg <= `LBI_PHASE_RESET;
      end else begin
         phaseReg <= ~phaseReg;
      end
   end
   assign tick = (phaseReg == `LBI_TICK_PHASE);
   assign adsSeen = !bus.addressStrobeN && !bus.holdGrantedOut;
   assign half = !bus.halfWidthRequestN;
   assign upperOnly = (curBeNReg[1:0] == `LBI_NO_LANES_N);
   // Upper bytes travel on the low lines of a half-width bus.
   assign rdDrive = (half && upperOnly) ?
      {rdData[`LBI_DATA_W-1:`LBI_HALF_W], rdData[`LBI_DATA_W-1:`LBI_HALF_W]} : rdData;
   assign wrTaken = (half && upperOnly) ?
      {bus.bidirDataLines[`LBI_HALF_W-1:0], bus.bidirDataLines[`LBI_HALF_W-1:0]} :
      bus.bidirDataLines;

   // ==========================================================
   // Steering inputs and hold
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bus.nextAddressRequestN <= 1'b1;
         bus.halfWidthRequestN <= 1'b1;
         bus.holdRequest <= 1'b0;
         holdGranted <= 1'b0;
      end else begin
         bus.nextAddressRequestN <= ~pipeEnable;
         bus.halfWidthRequestN <= ~halfWidthSel;
         bus.holdRequest <= holdRequestIn;
         holdGranted <= bus.holdGrantedOut;
      end
   end

   // ==========================================================
   // Cycle tracking and acknowledge
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         busyReg <= 1'b0;
         pendReg <= 1'b0;
         ackNReg <= 1'b1;
         waitCntReg <= `LBI_WAIT_ZERO;
         curAddrReg <= '0;
         curBeNReg <= '1;
         curDefReg <= '0;
         pendAddrReg <= '0;
         pendBeNReg <= '1;
         pendDefReg <= '0;
         bus.cycleAckN <= 1'b1;
         bus.hostData <= '0;
         bus.hostDataOe <= 1'b0;
         cycValid <= 1'b0;
         cycWordAddr <= '0;
         cycBeN <= '1;
         cycMio <= 1'b0;
         cycDc <= 1'b0;
         cycWr <= 1'b0;
         cycData <= '0;
      end else begin
         cycValid <= 1'b0;
         if (tick && busyReg && !ackNReg) begin
            // The device took the acknowledge at this edge.
            ackNReg <= 1'b1;
            bus.cycleAckN <= 1'b1;
            bus.hostDataOe <= 1'b0;
            cycValid <= 1'b1;
            cycWordAddr <= curAddrReg;
            cycBeN <= curBeNReg;
            {cycMio, cycDc, cycWr} <= curDefReg;
            cycData <= curDefReg[0] ? wrTaken : rdDrive;
            waitCntReg <= waitStates;
            pendReg <= 1'b0;
            if (adsSeen) begin
               curAddrReg <= bus.wordAddressOut;
               curBeNReg <= bus.byteLaneEnableN;
               curDefReg <= {bus.memIoSel, bus.dataCodeSel, bus.writeReadSel};
            end else if (pendReg) begin
               curAddrReg <= pendAddrReg;
               curBeNReg <= pendBeNReg;
               curDefReg <= pendDefReg;
            end else begin
               busyReg <= 1'b0;
            end
         end else if (tick && busyReg) begin
            if (adsSeen) begin
               pendReg <= 1'b1;
               pendAddrReg <= bus.wordAddressOut;
               pendBeNReg <= bus.byteLaneEnableN;
               pendDefReg <= {bus.memIoSel, bus.dataCodeSel, bus.writeReadSel};
            end
            if (waitCntReg == `LBI_WAIT_ZERO) begin
               ackNReg <= 1'b0;
               bus.cycleAckN <= 1'b0;
               bus.hostDataOe <= !curDefReg[0];
               bus.hostData <= rdDrive;
            end else begin
               waitCntReg <= waitCntReg - `LBI_WAIT_ONE;
            end
         end else if (tick && adsSeen) begin
            busyReg <= 1'b1;
            curAddrReg <= bus.wordAddressOut;
            curBeNReg <= bus.byteLaneEnableN;
            curDefReg <= {bus.memIoSel, bus.dataCodeSel, bus.writeReadSel};
            if (waitStates == `LBI_WAIT_ZERO) begin
               ackNReg <= 1'b0;
               bus.cycleAckN <= 1'b0;
               bus.hostDataOe <= !bus.writeReadSel;
               bus.hostData <= (half && bus.byteLaneEnableN[1:0] == `LBI_NO_LANES_N) ?
                  {rdData[`LBI_DATA_W-1:`LBI_HALF_W], rdData[`LBI_DATA_W-1:`LBI_HALF_W]} :
                  rdData;
            end else begin
               waitCntReg <= waitStates - `LBI_WAIT_ONE;
            end
         end
      end
   end
endmodule

// File: verilog/lbi_pkg.sv
// Types used by the device end of the local bus.
// Assumes lbi_cfg.svh is on the include path.
`include "lbi_cfg.svh"

package lbi_pkg;

   // ==========================================================
   // Bus states of the device end
   // ==========================================================
   typedef enum logic [2:0] {
      LBI_IDLE = 3'h0,
      LBI_T1 = 3'h1,
      LBI_T2 = 3'h3,
      LBI_P1 = 3'h2,
      LBI_HOLD = 3'h4
   } lbi_dev_state_t;

   // ==========================================================
   // One bus cycle as the device end holds it
   // ==========================================================
   typedef struct packed {
      logic [`LBI_WADDR_W-1:0] wordAddr;
      logic [`LBI_LANES-1:0] be;
      logic mio;
      logic dc;
      logic wr;
      logic [`LBI_DATA_W-1:0] data;
   } lbi_cyc_t;

endpackage
